// *** bct_pkg.sv ***
// Constants, reset values and types of the BCD calendar timekeeper.
// Assumes a 10 MHz system clock and a 32.768 kHz oscillator clock.
// Summary of operation
// [RULE1] Serial slave: start, id byte, sequential bytes, stop
// [RULE2] Below power-fail threshold: no access, time keeps counting
// [RULE3] After recovery, access waits out the delay
// [RULE4] No recovery delay while oscillator is stopped
// [RULE5] First power: 01/01/00, weekday 01, 00:00:00
// [RULE6] Pointer increments per byte, wraps past 10h
// [RULE7] Start or wrap to 00h snapshots time
// [RULE8] All time fields held in BCD digits
// [RULE9] Hours bit 6 high selects 12-hour counting
// [RULE10] Hours bit 5: PM flag or twenty-hours digit
// [RULE11] Host rewrites all hours after format change
// [RULE12] Year 99 to 00 flips the century bit
// [RULE13] Century zero: leap February 29, else 28
// [RULE14] Date rolls over after month's last day
// [RULE15] Weekday advances at midnight, sequential values
// [RULE16] Seconds write restarts the sub-second chain
// [RULE17] Written byte lands at device acknowledge
// [RULE18] Host finishes setting time within one second
// [RULE19] Square wave rises 500 ms after seconds write
// [RULE20] One-second base from 32.768 kHz oscillator
// [RULE21] Impossible values are neither checked nor corrected
// [RULE22] Seconds every 32768 cycles, fields carry upward
// [RULE23] 12-hour: 11 to 12 toggles PM, 12 to 01 not
package bct_pkg;
  // Timing
  localparam int CLK_MHZ = 10;
  localparam int ACCESS_RECOVERY_DELAY_US = 250;
  localparam logic [11:0] RECOVERY_CYCLES = 12'(ACCESS_RECOVERY_DELAY_US * CLK_MHZ);
  localparam logic [14:0] OSC_LAST = 15'h7fff;
  localparam int SQW_BIT = 14;
  // Serial identity, value arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h5a;
  // Register indices
  localparam logic [4:0] REG_SEC = 5'h00;
  localparam logic [4:0] REG_YEAR = 5'h06;
  localparam logic [4:0] REG_LAST = 5'h10;
  // Field positions
  localparam int HR_MODE12_BIT = 6;
  localparam int HR_PM_BIT = 5;
  localparam int MON_CENT_BIT = 7;
  // Reset values and writable bits, index 0 seconds to 6 year
  localparam logic [7:0] TK_RST [0:6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  localparam logic [7:0] WR_MASK [0:6] = '{8'h7f, 8'h7f, 8'h7f, 8'h07, 8'h3f, 8'h9f, 8'hff};
  // Serial slave states
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_RX = 5'b00010,
    S_ACK = 5'b00100,
    S_TX = 5'b01000,
    S_MACK = 5'b10000
  } bct_state_t;
endpackage : bct_pkg

// *** bct_timekeeper.sv ***
// BCD calendar timekeeper with a serial slave port and square-wave output.
// Assumes SCL, SDA and the power-fail level are raw pins; OSC_CLK is the crystal clock.
`timescale 1ns/1ps
`default_nettype none
module bct_timekeeper (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  input wire logic OSC_CLK,
  input wire logic OSC_EN,
  input wire logic SQW_EN,
  input wire logic BELOW_POWER_FAIL_THRESHOLD,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  output logic SQUARE_WAVE_IRQ_OUT,
  output logic SQUARE_WAVE_IRQ_OE_N,
  output logic ACCESS_READY
);
  import bct_pkg::*;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction : bcd_inc

  logic [2:0] scl_sync, sda_sync, tick_sync;
  logic [1:0] pf_sync;
  logic scl_rise, scl_fall, start, stop, pf_s, tick;
  bct_state_t st, next_st;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg, rd_byte;
  logic [4:0] ptr, next_ptr;
  logic is_addr, next_is_addr, have_ptr, next_have_ptr, rd, next_rd;
  logic sda_oe_n, next_sda_oe_n, wr_en, ptr_inc, snap;
  logic [11:0] rcv_cnt, next_rcv_cnt;
  logic next_access;
  logic [7:0] tk [0:6];
  logic [7:0] next_tk [0:6];
  logic [7:0] shadow [0:6];
  logic [7:0] next_shadow [0:6];
  logic chain_tgl, next_chain_tgl, tick_tgl;
  logic min_c, hr_c, day_c, mon_c, yr_c, leap;
  logic [7:0] hr_inc, mon_inc, last_day;

  // Pin and tick synchronisers, stage 0 feeds only stage 1
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      tick_sync <= 3'h0;
      pf_sync <= 2'h3;
    end else if (CE) begin
      scl_sync <= {scl_sync[1:0], SCL_IN};
      sda_sync <= {sda_sync[1:0], SDA_IN};
      tick_sync <= {tick_sync[1:0], tick_tgl};
      pf_sync <= {pf_sync[0], BELOW_POWER_FAIL_THRESHOLD};
    end
  end

  // Bus conditions from synchronised levels
  assign scl_rise = scl_sync[1] && !scl_sync[2];
  assign scl_fall = !scl_sync[1] && scl_sync[2];
  assign start = scl_sync[1] && scl_sync[2] && sda_sync[2] && !sda_sync[1];
  assign stop = scl_sync[1] && scl_sync[2] && !sda_sync[2] && sda_sync[1];
  assign pf_s = pf_sync[1];
  assign tick = tick_sync[1] ^ tick_sync[2];
  assign rd_byte = (ptr <= REG_YEAR) ? shadow[ptr[2:0]] : 8'h00;

  // Access gate: blocked under threshold, then recovery count
  always_comb begin
    next_rcv_cnt = rcv_cnt;
    if (pf_s) begin
      next_rcv_cnt = OSC_EN ? RECOVERY_CYCLES : 12'h000; // RULE2 RULE4
    end else if (rcv_cnt != 12'h000) begin
      next_rcv_cnt = OSC_EN ? rcv_cnt - 12'h001 : 12'h000; // RULE3 RULE4
    end
    next_access = !pf_s && (next_rcv_cnt == 12'h000); // RULE2 RULE3
  end

  // Serial slave next state
  always_comb begin
    next_st = st;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_is_addr = is_addr;
    next_have_ptr = have_ptr;
    next_rd = rd;
    next_sda_oe_n = sda_oe_n;
    wr_en = 1'b0;
    ptr_inc = 1'b0;
    if (stop || !ACCESS_READY) begin
      next_st = S_IDLE; // RULE1 RULE2
      next_sda_oe_n = 1'b1;
    end else if (start) begin
      next_st = S_RX; // RULE1
      next_bit_cnt = 4'h0;
      next_is_addr = 1'b1;
      next_have_ptr = 1'b0;
      next_sda_oe_n = 1'b1;
    end else begin
      unique case (st)
        S_IDLE: begin
          next_sda_oe_n = 1'b1;
        end
        S_RX: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_sync[1]};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            next_st = S_ACK;
            next_sda_oe_n = 1'b0;
            next_is_addr = 1'b0;
            if (is_addr) begin
              next_rd = shreg[0];
              if (shreg[7:1] != DEV_ADDR) begin
                next_st = S_IDLE;
                next_sda_oe_n = 1'b1;
              end
            end else if (!have_ptr) begin
              next_ptr = shreg[4:0];
              next_have_ptr = 1'b1;
            end else begin
              wr_en = 1'b1; // RULE17
              ptr_inc = 1'b1; // RULE6
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if (rd) begin
              next_st = S_TX;
              next_shreg = rd_byte; // RULE7
              next_sda_oe_n = rd_byte[7];
            end else begin
              next_st = S_RX;
              next_sda_oe_n = 1'b1;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == 4'h7) begin
              next_st = S_MACK;
              next_sda_oe_n = 1'b1;
              ptr_inc = 1'b1; // RULE6
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_sda_oe_n = shreg[6];
            end
          end
        end
        S_MACK: begin
          if (scl_rise && sda_sync[1]) begin
            next_st = S_IDLE;
          end else if (scl_fall) begin
            next_st = S_TX;
            next_bit_cnt = 4'h0;
            next_shreg = rd_byte;
            next_sda_oe_n = rd_byte[7];
          end
        end
      endcase
    end
    if (ptr_inc) begin
      next_ptr = (ptr >= REG_LAST) ? 5'h00 : ptr + 5'h01; // RULE6
    end
    snap = start || (ptr_inc && next_ptr == 5'h00); // RULE7
  end

  // Month length and leap year in BCD
  always_comb begin
    leap = tk[6][4] ? (tk[6][3:0] == 4'h2 || tk[6][3:0] == 4'h6)
                    : (tk[6][3:0] == 4'h0 || tk[6][3:0] == 4'h4 || tk[6][3:0] == 4'h8);
    case (tk[5][4:0])
      5'h02: last_day = (leap && !tk[5][MON_CENT_BIT]) ? 8'h29 : 8'h28; // RULE13
      5'h04, 5'h06, 5'h09, 5'h11: last_day = 8'h30; // RULE14
      default: last_day = 8'h31;
    endcase
    hr_inc = tk[2][HR_MODE12_BIT] ? bcd_inc({3'b000, tk[2][4:0]}) : bcd_inc({2'b00, tk[2][5:0]});
    mon_inc = bcd_inc({3'b000, tk[5][4:0]}); // Month digits without the century bit
  end

  // Timekeeping counters, writes and read snapshot
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      next_tk[i] = tk[i];
      next_shadow[i] = snap ? tk[i] : shadow[i]; // RULE7
    end
    next_chain_tgl = chain_tgl;
    min_c = 1'b0;
    hr_c = 1'b0;
    day_c = 1'b0;
    mon_c = 1'b0;
    yr_c = 1'b0;
    if (wr_en) begin
      if (ptr <= REG_YEAR) begin
        next_tk[ptr[2:0]] = shreg & WR_MASK[ptr[2:0]]; // RULE8 RULE17 RULE21
      end
      if (ptr == REG_SEC) begin
        next_chain_tgl = !chain_tgl; // RULE16
      end
    end else if (tick) begin
      if (tk[0] == 8'h59) begin
        next_tk[0] = 8'h00; // RULE22
        min_c = 1'b1;
      end else begin
        next_tk[0] = bcd_inc(tk[0]); // RULE8
      end
      if (min_c) begin
        hr_c = (tk[1] == 8'h59);
        next_tk[1] = hr_c ? 8'h00 : bcd_inc(tk[1]);
      end
      if (hr_c) begin
        if (tk[2][HR_MODE12_BIT]) begin
          if (tk[2][4:0] == 5'h11) begin
            next_tk[2] = {tk[2][7:6], ~tk[2][HR_PM_BIT], 5'h12}; // RULE10 RULE23
            day_c = tk[2][HR_PM_BIT];
          end else if (tk[2][4:0] == 5'h12) begin
            next_tk[2] = {tk[2][7:5], 5'h01}; // RULE23
          end else begin
            next_tk[2] = {tk[2][7:5], hr_inc[4:0]}; // RULE9
          end
        end else if (tk[2][5:0] == 6'h23) begin
          next_tk[2] = {tk[2][7:6], 6'h00}; // RULE10
          day_c = 1'b1;
        end else begin
          next_tk[2] = {tk[2][7:6], hr_inc[5:0]}; // RULE9
        end
      end
      if (day_c) begin
        next_tk[3] = (tk[3] == 8'h07) ? 8'h01 : tk[3] + 8'h01; // RULE15
        mon_c = (tk[4] == last_day);
        next_tk[4] = mon_c ? 8'h01 : bcd_inc(tk[4]); // RULE14
      end
      if (mon_c) begin
        yr_c = (tk[5][4:0] == 5'h12);
        next_tk[5] = {tk[5][7:5], yr_c ? 5'h01 : mon_inc[4:0]}; // RULE14
      end
      if (yr_c) begin
        next_tk[6] = (tk[6] == 8'h99) ? 8'h00 : bcd_inc(tk[6]);
        if (tk[6] == 8'h99) begin
          next_tk[5][MON_CENT_BIT] = ~tk[5][MON_CENT_BIT]; // RULE12
        end
      end
    end
  end

  // System-domain registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st <= S_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 5'h00;
      is_addr <= 1'b0;
      have_ptr <= 1'b0;
      rd <= 1'b0;
      sda_oe_n <= 1'b1;
      SDA_OE_N <= 1'b1;
      SDA_OUT <= 1'b0;
      rcv_cnt <= 12'h000;
      ACCESS_READY <= 1'b0;
      chain_tgl <= 1'b0;
      for (int i = 0; i < 7; i++) begin
        tk[i] <= TK_RST[i]; // RULE5
        shadow[i] <= TK_RST[i];
      end
    end else if (CE) begin
      st <= next_st;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      is_addr <= next_is_addr;
      have_ptr <= next_have_ptr;
      rd <= next_rd;
      sda_oe_n <= next_sda_oe_n;
      SDA_OE_N <= next_sda_oe_n;
      SDA_OUT <= 1'b0;
      rcv_cnt <= next_rcv_cnt;
      ACCESS_READY <= next_access;
      chain_tgl <= next_chain_tgl;
      tk <= next_tk;
      shadow <= next_shadow;
    end
  end

  // Oscillator domain: prescaler and square wave
  logic [1:0] orst_sync, oen_sync, osq_sync;
  logic [2:0] oclr_sync;
  logic orst, chain_clear, next_tick_tgl, next_sqw_oe_n;
  logic [14:0] presc, next_presc;
  assign orst = orst_sync[1];
  assign chain_clear = oclr_sync[1] ^ oclr_sync[2];

  always_comb begin
    next_presc = presc;
    next_tick_tgl = tick_tgl;
    if (chain_clear) begin
      next_presc = 15'h0000; // RULE16
    end else if (oen_sync[1]) begin
      next_presc = presc + 15'h0001; // RULE20
      if (presc == OSC_LAST) begin
        next_tick_tgl = !tick_tgl; // RULE22
      end
    end
    next_sqw_oe_n = !(osq_sync[1] && oen_sync[1]) || next_presc[SQW_BIT]; // RULE19
  end

  always_ff @(posedge OSC_CLK) begin
    orst_sync <= {orst_sync[0], RST};
    if (orst) begin
      oen_sync <= 2'h0;
      osq_sync <= 2'h0;
      oclr_sync <= 3'h0;
      presc <= 15'h0000;
      tick_tgl <= 1'b0;
      SQUARE_WAVE_IRQ_OE_N <= 1'b1;
      SQUARE_WAVE_IRQ_OUT <= 1'b0;
    end else begin
      oen_sync <= {oen_sync[0], OSC_EN};
      osq_sync <= {osq_sync[0], SQW_EN};
      oclr_sync <= {oclr_sync[1:0], chain_tgl};
      presc <= next_presc;
      tick_tgl <= next_tick_tgl;
      SQUARE_WAVE_IRQ_OE_N <= next_sqw_oe_n;
      SQUARE_WAVE_IRQ_OUT <= 1'b0;
    end
  end

  // Checks
  sequence s_sec_write;
    CE && wr_en && ptr == REG_SEC;
  endsequence
  chk_block_under_pf: assert property (@(posedge CLK_SYS) disable iff (RST) (CE && pf_s) |=> !ACCESS_READY) // RULE2
    else $error("access open below threshold");
  chk_recovery_wait: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && pf_s && OSC_EN) |=> !ACCESS_READY [*8]) // RULE3
    else $error("access reopened before recovery delay");
  chk_no_delay_stopped: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && !pf_s && !OSC_EN) |=> ACCESS_READY) // RULE4
    else $error("delay applied with oscillator stopped");
  chk_sec_write_restart: assert property (@(posedge CLK_SYS) disable iff (RST)
    s_sec_write |=> chain_tgl != $past(chain_tgl)) // RULE16
    else $error("seconds write did not restart chain");
  chk_ptr_wrap: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && ptr_inc && ptr == REG_LAST) |=> ptr == 5'h00 && shadow[0] == $past(tk[0])) // RULE6
    else $error("pointer wrap or snapshot wrong");
  chk_snap_on_start: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && start) |=> shadow[2] == $past(tk[2])) // RULE7
    else $error("no snapshot on start");
  chk_century_flip: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && !wr_en && tk[6] == 8'h99) ##1 tk[6] == 8'h00 |-> tk[5][7] != $past(tk[5][7])) // RULE12
    else $error("century bit not flipped");
  chk_sec_wrap: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && tick && !wr_en && tk[0] == 8'h59) |=> tk[0] == 8'h00 && tk[1] != $past(tk[1])) // RULE22
    else $error("seconds carry wrong");
  chk_noon_pm: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CE && hr_c && !wr_en && tk[2][6] && tk[2][4:0] == 5'h11) |=> tk[2][5] != $past(tk[2][5])) // RULE23
    else $error("PM flag not toggled at 11 to 12");
  chk_sqw_low_after_clr: assert property (@(posedge OSC_CLK) disable iff (orst)
    (chain_clear && osq_sync[1] && oen_sync[1]) |=> SQUARE_WAVE_IRQ_OE_N == 1'b0 [*8]) // RULE19
    else $error("square wave high too soon after seconds write");
endmodule : bct_timekeeper
`default_nettype wire

// *** bct_i2c_master.sv ***
// Two-wire bus master model that drives the timekeeper's serial port.
// Assumes pull-ups on both lines; the bench resolves the shared data wire.
`timescale 1ns/1ps
`default_nettype none
module bct_i2c_master (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // Both lines released while idle
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Half bit period, twelve system clocks
  task automatic hp;
    repeat (12) @(posedge clk);
  endtask : hp
  // Start or repeated start: data falls while clock is high
  task automatic start;
    sda_drv <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_drv <= 1'b0;
    hp();
    scl <= 1'b0;
    hp();
  endtask : start
  // Stop: data rises while clock is high
  task automatic stop;
    sda_drv <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_drv <= 1'b1;
    hp();
  endtask : stop
  // One bit: data set while clock low, sampled at end of high phase
  task automatic xbit(input logic b, output logic r);
    sda_drv <= b;
    hp();
    scl <= 1'b1;
    hp();
    r = sda_line;
    scl <= 1'b0;
    @(posedge clk);
  endtask : xbit
  // Byte out, most significant bit first; returns acknowledge level
  task automatic send(input logic [7:0] b, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(b[i], r);
    xbit(1'b1, ack_n);
  endtask : send
  // Byte in; the last byte of a read is not acknowledged
  task automatic recv(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(1'b1, b[i]);
    xbit(last, r);
  endtask : recv
endmodule : bct_i2c_master
`default_nettype wire

// *** bct_timekeeper_test.sv ***
// Self-checking bench for the timekeeper: calendar carries, access blocking, snapshots.
// Assumes bct_pkg and the bus master model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module bct_timekeeper_test;
  import bct_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, osc_clk = 1'b0, osc_en = 1'b1, below = 1'b1;
  logic scl, sda_drv, sda_out, sda_oe_n, sqw_out, sqw_oe_n, ready, sda_line, ack_n;
  logic armed = 1'b0;
  logic [7:0] wbuf [0:6];
  logic [7:0] rd [0:17];
  realtime t_sec = 0, t_rise = 0;
  int err_total = 0, comparisons = 0;
  // Set value then value after one tick: sec min hour wday date month year
  logic [7:0] cases [0:6][0:13] = '{
    '{8'h59, 8'h59, 8'h23, 8'h03, 8'h28, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00, 8'h04, 8'h29, 8'h02, 8'h04},
    '{8'h59, 8'h59, 8'h23, 8'h05, 8'h28, 8'h82, 8'h04, 8'h00, 8'h00, 8'h00, 8'h06, 8'h01, 8'h83, 8'h04},
    '{8'h59, 8'h59, 8'h23, 8'h01, 8'h30, 8'h04, 8'h99, 8'h00, 8'h00, 8'h00, 8'h02, 8'h01, 8'h05, 8'h99},
    '{8'h59, 8'h59, 8'h23, 8'h02, 8'h31, 8'h12, 8'h99, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01, 8'h81, 8'h00},
    '{8'h59, 8'h59, 8'h51, 8'h07, 8'h15, 8'h06, 8'h10, 8'h00, 8'h00, 8'h72, 8'h07, 8'h15, 8'h06, 8'h10},
    '{8'h59, 8'h59, 8'h72, 8'h07, 8'h15, 8'h06, 8'h10, 8'h00, 8'h00, 8'h61, 8'h07, 8'h15, 8'h06, 8'h10},
    '{8'h59, 8'h59, 8'h19, 8'h07, 8'h15, 8'h06, 8'h10, 8'h00, 8'h00, 8'h20, 8'h07, 8'h15, 8'h06, 8'h10}};
  // Open-drain data wire with pull-up
  assign sda_line = sda_drv & (sda_oe_n | sda_out);
  // System clock 100 ns, oscillator 12 ns with unrelated phase
  always #50 clk_sys = ~clk_sys;
  initial begin
    #3.3;
    forever #6 osc_clk = ~osc_clk;
  end
  // First square-wave release after a seconds write
  always @(posedge sqw_oe_n) begin
    if (armed) begin
      t_rise = $realtime;
      armed = 1'b0;
    end
  end
  bct_timekeeper dut (.CLK_SYS(clk_sys), .RST(rst), .CE(1'b1), .OSC_CLK(osc_clk), .OSC_EN(osc_en),
    .SQW_EN(1'b1), .BELOW_POWER_FAIL_THRESHOLD(below), .SCL_IN(scl), .SDA_IN(sda_line),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .SQUARE_WAVE_IRQ_OUT(sqw_out),
    .SQUARE_WAVE_IRQ_OE_N(sqw_oe_n), .ACCESS_READY(ready));
  bct_i2c_master m (.clk(clk_sys), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  // Comparisons of bytes and of flags
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic chk1(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1
  // Address the device for writing and set the pointer to zero
  task automatic addr_ptr;
    m.start();
    m.send({DEV_ADDR, 1'b0}, ack_n);
    chk1("addr_ack", 1'b0, ack_n);
    m.send(8'h00, ack_n);
    chk1("ptr_ack", 1'b0, ack_n);
  endtask : addr_ptr
  task automatic write_regs(input int n);
    addr_ptr();
    for (int i = 0; i < n; i++) begin
      m.send(wbuf[i], ack_n);
      t_sec = (i == 0) ? $realtime : t_sec;
      armed = armed | (i == 0);
      chk1("data_ack", 1'b0, ack_n);
    end
    m.stop();
  endtask : write_regs
  task automatic read_regs(input int n);
    addr_ptr();
    m.start();
    m.send({DEV_ADDR, 1'b1}, ack_n);
    chk1("rd_ack", 1'b0, ack_n);
    for (int i = 0; i < n; i++) m.recv(i == n - 1, rd[i]);
    m.stop();
  endtask : read_regs
  task automatic wait_ready(output int n);
    n = 0;
    while (ready !== 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_ready
  function automatic logic [7:0] bcd_next(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction : bcd_next
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  // Cut a hang short
  initial begin
    #9_800_000;
    err_total++;
    print_verdict();
  end
  // Main sequence
  initial begin
    int n;
    logic [7:0] s;
    void'($urandom(32'h5d61));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    below <= 1'b0;
    @(posedge clk_sys);
    chk1("ready_rst", 1'b0, ready);
    wait_ready(n);
    chk1("recovery", 1'b1, n >= int'(RECOVERY_CYCLES) - 1 && n <= int'(RECOVERY_CYCLES) + 15);
    read_regs(18);
    for (int i = 0; i < 17; i++) chk8("reset_reg", (i < 7) ? TK_RST[i] : 8'h00, rd[i]);
    chk8("wrap_snap", 8'h01, rd[17]);
    for (int c = 0; c < 7; c++) begin
      for (int i = 0; i < 7; i++) wbuf[i] = cases[c][i];
      write_regs(7);
      read_regs(1);
      chk8("sec_held", 8'h59, rd[0]);
      repeat (2000) @(posedge clk_sys);
      read_regs(7);
      for (int i = 0; i < 7; i++) chk8("tick", cases[c][i + 7], rd[i]);
      chk1("sqw_rise", 1'b1, t_rise - t_sec > 190000 && t_rise - t_sec < 200000);
    end
    for (int k = 0; k < 2; k++) begin
      s = {1'b0, 3'($urandom % 5), 4'($urandom % 10)};
      wbuf[0] = s;
      write_regs(1);
      if (k == 1) begin
        below <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chk1("ready_fail", 1'b0, ready);
        m.start();
        m.send({DEV_ADDR, 1'b0}, ack_n);
        chk1("refused", 1'b1, ack_n);
        m.stop();
        repeat (2700) @(posedge clk_sys);
        below <= 1'b0;
        wait_ready(n);
        chk1("recovery", 1'b1, n >= int'(RECOVERY_CYCLES) - 1 && n <= int'(RECOVERY_CYCLES) + 15);
      end else begin
        repeat (4000) @(posedge clk_sys);
      end
      read_regs(1);
      chk8("sec_tick", bcd_next(s), rd[0]);
    end
    osc_en <= 1'b0;
    below <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk1("ready_fail", 1'b0, ready);
    below <= 1'b0;
    wait_ready(n);
    chk1("no_delay", 1'b1, n <= 8);
    chk1("sda_out", 1'b0, sda_out);
    chk1("sqw_out", 1'b0, sqw_out);
    print_verdict();
  end
endmodule : bct_timekeeper_test
`default_nettype wire
